// File: irq_vec_pkg.sv
// constants shared by the vector address logic: table spacing, vector
// numbers of reset and nine sources and ten fixed addresses of the larger table.
// assumes word addressing of program memory, vector number 1 is reset.

package irq_vec_pkg;

   // ==========================================================
   // geometry
   // ==========================================================
   localparam int NUM_SRC = 25;            // interrupt sources, no reset
   localparam int ADDR_W = 13;             // word address width
   localparam int NUM_W = 5;               // vector number width
   localparam int SPACE_LARGE = 2;         // words per slot, larger part
   localparam int SPACE_SMALL = 1;         // words per slot, smaller part
   localparam logic [ADDR_W-1:0] RESET_ADDR = 13'h0000;

   // ==========================================================
   // vector numbers (slot index is number minus one)
   // ==========================================================
   localparam logic [NUM_W-1:0] VEC_RESET = 5'h01;
   localparam logic [NUM_W-1:0] VEC_EXT0 = 5'h02;  // first interrupt
   localparam logic [NUM_W-1:0] VEC_PCHG0 = 5'h04;
   localparam logic [NUM_W-1:0] VEC_TIM2A = 5'h08;
   localparam logic [NUM_W-1:0] VEC_TIM1CAP = 5'h0b;
   localparam logic [NUM_W-1:0] VEC_TIM0A = 5'h0f;
   localparam logic [NUM_W-1:0] VEC_SPI = 5'h12;
   localparam logic [NUM_W-1:0] VEC_USART_RX = 5'h13;
   localparam logic [NUM_W-1:0] VEC_ADC = 5'h16;
   localparam logic [NUM_W-1:0] VEC_SPM = 5'h1a;   // last interrupt

   // ==========================================================
   // fixed addresses of the larger base table
   // ==========================================================
   localparam logic [ADDR_W-1:0] ADDR_EXT0 = 13'h0002;
   localparam logic [ADDR_W-1:0] ADDR_EXT1 = 13'h0004;
   localparam logic [ADDR_W-1:0] ADDR_PCHG0 = 13'h0006;
   localparam logic [ADDR_W-1:0] ADDR_TIM2A = 13'h000e;
   localparam logic [ADDR_W-1:0] ADDR_TIM1CAP = 13'h0014;
   localparam logic [ADDR_W-1:0] ADDR_TIM0A = 13'h001c;
   localparam logic [ADDR_W-1:0] ADDR_SPI = 13'h0022;
   localparam logic [ADDR_W-1:0] ADDR_USART_RX = 13'h0024;
   localparam logic [ADDR_W-1:0] ADDR_ADC = 13'h002a;
   localparam logic [ADDR_W-1:0] ADDR_SPM = 13'h0032;

   // smaller part, 2K boot section
   localparam logic [ADDR_W-1:0] BOOT_2K_SMALL = 13'h0c00;
   localparam logic [ADDR_W-1:0] ADDR_SMALL_FIRST = 13'h0c01;
   localparam logic [ADDR_W-1:0] ADDR_SMALL_LAST = 13'h0c19;

endpackage

// File: irq_priority_pick.sv
// lowest-numbered pending request picker.
// assumes request bit 0 is the source with the lowest vector number.
`timescale 1ns/100ps
`default_nettype none

module irq_priority_pick #(
   parameter int N = 25,
   parameter int IW = 5
) (
   input wire logic [N-1:0] pend,
   output logic any,
   output logic [IW-1:0] idx
);

   // ==========================================================
   // scan from the top so the lowest set bit wins
   // ==========================================================
   always_comb begin
      any = 1'b0;
      idx = '0;
      for (int i = N - 1; i >= 0; i--) begin
         if (pend[i]) begin
            any = 1'b1;
            idx = IW'(i);
         end
      end
   end

endmodule
`default_nettype wire

// File: vector_addr_gen.sv
// program address of a vector slot, for either table layout.
// assumes the boot section start arrives as a word address.
`timescale 1ns/100ps
`default_nettype none

module vector_addr_gen #(
   parameter bit LARGE = 1'b1,
   parameter int AW = 13
) (
   input wire logic [4:0] slot,
   input wire logic is_reset,
   input wire logic boot_reset_fuse,
   input wire logic vector_relocate_bit,
   input wire logic [AW-1:0] boot_start,
   output logic [AW-1:0] addr
);

   logic [AW-1:0] offset; // slot times spacing
   logic [AW-1:0] base;   // table origin

   // ==========================================================
   // reset entry and relocated table origin
   // ==========================================================
   always_comb begin
      // larger part uses two-word jumps, smaller one-word jumps
      offset = LARGE ? AW'({slot, 1'b0}) : AW'(slot);
      if (is_reset) begin
         // fuse reads 1 while unprogrammed
         base = boot_reset_fuse ? irq_vec_pkg::RESET_ADDR : boot_start;
         addr = base;
      end else begin
         base = vector_relocate_bit ? boot_start : irq_vec_pkg::RESET_ADDR;
         addr = AW'(base + offset);
      end
   end

endmodule
`default_nettype wire

// File: interrupt_vector_map.sv
// reset and interrupt vector address generator for the core fetch unit.
// assumes requests are levels held by their sources until acknowledged,
// and that fuse, relocation bit and boot start are quasi-static.
`timescale 1ns/100ps
`default_nettype none

module interrupt_vector_map #(
   parameter bit LARGE_VARIANT = 1'b1,
   parameter int N = irq_vec_pkg::NUM_SRC,
   parameter int AW = irq_vec_pkg::ADDR_W
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [N-1:0] irq_req,
   input wire logic irq_enable,
   input wire logic boot_reset_fuse,
   input wire logic vector_relocate_bit,
   input wire logic [AW-1:0] boot_start,
   input wire logic vector_take,
   output logic fetch_valid_r,
   output logic [AW-1:0] fetch_addr_r,
   output logic [4:0] fetch_num_r,
   output logic fetch_is_reset_r,
   output logic [N-1:0] irq_ack_r
);

   // ==========================================================
   // types and decode helpers
   // ==========================================================
   typedef enum logic [1:0] {
      ST_BOOT,  // offer the reset entry once
      ST_IDLE,  // wait for an enabled request
      ST_OFFER  // hold vector until the core takes it
   } vec_state_e;

   // one-hot acknowledge for a vector number
   function automatic logic [N-1:0] ack_of(input logic [4:0] num);
      logic [4:0] src;
      src = 5'(num - irq_vec_pkg::VEC_EXT0);
      ack_of = '0;
      ack_of[src] = 1'b1;
   endfunction

   vec_state_e state_r;        // offer sequencer
   vec_state_e state_nxt;      // its next value
   logic [N-1:0] pend;         // enabled requests not yet acknowledged
   logic any_pend;             // a request is waiting
   logic [4:0] win_idx;        // lowest pending source index
   logic [4:0] slot;           // table slot to translate
   logic load_reset;           // capture the reset entry
   logic load_irq;             // capture an interrupt entry
   logic taken;                // core consumed the offer
   logic [AW-1:0] gen_addr;    // translated address

   // ==========================================================
   // request qualification and arbitration
   // ==========================================================
   // masking the bit just acknowledged avoids a double take while
   // the source is still dropping its level
   always_comb begin
      pend = irq_req & ~irq_ack_r & {N{irq_enable}};
   end

   irq_priority_pick #(
      .N(N),
      .IW(5)
   ) u_pick (
      .pend(pend),
      .any(any_pend),
      .idx(win_idx)
   );

   // ==========================================================
   // address translation
   // ==========================================================
   always_comb begin
      load_reset = (state_r == ST_BOOT);
      load_irq = (state_r == ST_IDLE) && any_pend;
      taken = (state_r == ST_OFFER) && vector_take;
      // slot 0 is the reset entry, sources follow one slot each
      slot = load_reset ? 5'h00 : 5'(win_idx + 5'h01);
   end

   vector_addr_gen #(
      .LARGE(LARGE_VARIANT),
      .AW(AW)
   ) u_addr (
      .slot(slot),
      .is_reset(load_reset),
      .boot_reset_fuse(boot_reset_fuse),
      .vector_relocate_bit(vector_relocate_bit),
      .boot_start(boot_start),
      .addr(gen_addr)
   );

   // ==========================================================
   // sequencer
   // ==========================================================
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_BOOT: begin
            state_nxt = ST_OFFER;
         end
         ST_IDLE: begin
            // nothing moves until an enabled request is pending
            if (any_pend) begin
               state_nxt = ST_OFFER;
            end
         end
         ST_OFFER: begin
            if (vector_take) begin
               state_nxt = ST_IDLE;
            end
         end
      endcase
   end

   // state register
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= ST_BOOT;
      end else begin
         state_r <= state_nxt;
      end
   end

   // ==========================================================
   // fetch offer towards the core
   // ==========================================================
   // address is frozen while offered, so a late change of the
   // relocation bit cannot tear a fetch in progress
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         fetch_valid_r <= 1'b0;
         fetch_addr_r <= '0;
         fetch_num_r <= 5'h00;
         fetch_is_reset_r <= 1'b0;
      end else if (load_reset) begin
         fetch_valid_r <= 1'b1;
         fetch_addr_r <= gen_addr;
         fetch_num_r <= irq_vec_pkg::VEC_RESET;
         fetch_is_reset_r <= 1'b1;
      end else if (load_irq) begin
         fetch_valid_r <= 1'b1;
         fetch_addr_r <= gen_addr;
         fetch_num_r <= 5'(win_idx + irq_vec_pkg::VEC_EXT0);
         fetch_is_reset_r <= 1'b0;
      end else if (taken) begin
         fetch_valid_r <= 1'b0;
      end
   end

   // ==========================================================
   // acknowledge back to the requesting source
   // ==========================================================
   // one-cycle pulse; the reset entry has no source to clear
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_ack_r <= '0;
      end else if (taken && !fetch_is_reset_r) begin
         irq_ack_r <= ack_of(fetch_num_r);
      end else begin
         irq_ack_r <= '0;
      end
   end

   // ==========================================================
   // checks
   // ==========================================================
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   logic valid_d_r; // offer level one cycle ago
   logic new_irq;   // an interrupt offer appears this cycle

   // delayed offer level; a plain flop so the fresh-offer flag can be
   // built in ordinary logic and shared by several checks
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         valid_d_r <= 1'b0;
      end else begin
         valid_d_r <= fetch_valid_r;
      end
   end

   // fresh interrupt offer: level high now, low one cycle ago
   always_comb begin
      new_irq = fetch_valid_r && !valid_d_r && !fetch_is_reset_r;
   end

   AST_RESET_ZERO: assert property (
      $rose(fetch_valid_r) && fetch_is_reset_r && $past(boot_reset_fuse)
      |-> fetch_addr_r == irq_vec_pkg::RESET_ADDR)
      else $error("reset entry not at zero with fuse unprogrammed");

   AST_RESET_BOOT: assert property (
      $rose(fetch_valid_r) && fetch_is_reset_r && !$past(boot_reset_fuse)
      |-> fetch_addr_r == $past(boot_start))
      else $error("reset entry not at boot start with fuse programmed");

   AST_BASE_FIRST: assert property (
      new_irq && LARGE_VARIANT && !$past(vector_relocate_bit)
      |-> (fetch_num_r != irq_vec_pkg::VEC_EXT0
           || fetch_addr_r == irq_vec_pkg::ADDR_EXT0)
       && (fetch_num_r != 5'(irq_vec_pkg::VEC_EXT0 + 5'h01)
           || fetch_addr_r == irq_vec_pkg::ADDR_EXT1)
       && (fetch_num_r != irq_vec_pkg::VEC_PCHG0
           || fetch_addr_r == irq_vec_pkg::ADDR_PCHG0)
       && (fetch_num_r != irq_vec_pkg::VEC_TIM2A
           || fetch_addr_r == irq_vec_pkg::ADDR_TIM2A))
      else $error("wrong base address for early vector");

   AST_BASE_MID: assert property (
      new_irq && LARGE_VARIANT && !$past(vector_relocate_bit)
      |-> (fetch_num_r != irq_vec_pkg::VEC_TIM1CAP
           || fetch_addr_r == irq_vec_pkg::ADDR_TIM1CAP)
       && (fetch_num_r != irq_vec_pkg::VEC_TIM0A
           || fetch_addr_r == irq_vec_pkg::ADDR_TIM0A)
       && (fetch_num_r != irq_vec_pkg::VEC_SPI
           || fetch_addr_r == irq_vec_pkg::ADDR_SPI)
       && (fetch_num_r != irq_vec_pkg::VEC_USART_RX
           || fetch_addr_r == irq_vec_pkg::ADDR_USART_RX))
      else $error("wrong base address for middle vector");

   AST_BASE_LAST: assert property (
      new_irq && LARGE_VARIANT && !$past(vector_relocate_bit)
      && (fetch_num_r == irq_vec_pkg::VEC_ADC
          || fetch_num_r == irq_vec_pkg::VEC_SPM)
      |-> fetch_addr_r == ((fetch_num_r == irq_vec_pkg::VEC_ADC)
          ? irq_vec_pkg::ADDR_ADC : irq_vec_pkg::ADDR_SPM))
      else $error("wrong base address for late vector");

   AST_RELOCATE: assert property (
      new_irq && $past(vector_relocate_bit)
      |-> fetch_addr_r == AW'($past(boot_start)
          + (fetch_num_r - 5'h01) * (LARGE_VARIANT
          ? irq_vec_pkg::SPACE_LARGE : irq_vec_pkg::SPACE_SMALL)))
      else $error("relocated vector not offset by boot start");

   AST_SMALL_2K: assert property (
      new_irq && !LARGE_VARIANT && $past(vector_relocate_bit)
      && $past(boot_start) == irq_vec_pkg::BOOT_2K_SMALL
      |-> fetch_addr_r >= irq_vec_pkg::ADDR_SMALL_FIRST
       && fetch_addr_r <= irq_vec_pkg::ADDR_SMALL_LAST)
      else $error("small table outside 0xC01..0xC19");

   AST_ONLY_TAKEN: assert property (
      new_irq |-> $past(irq_enable)
      && ($past(irq_req & ~irq_ack_r) & ack_of(fetch_num_r)) != '0)
      else $error("vector offered without a pending request");

   AST_LOWEST_FIRST: assert property (
      new_irq |-> ($past(pend) & ((N'(1) << (fetch_num_r
      - irq_vec_pkg::VEC_EXT0)) - N'(1))) == '0)
      else $error("a lower vector was pending but skipped");

   AST_ACK_PULSE: assert property (
      fetch_valid_r && vector_take && !fetch_is_reset_r
      |=> irq_ack_r == ack_of($past(fetch_num_r)) && !fetch_valid_r
      ##1 irq_ack_r == '0)
      else $error("acknowledge missing or not a single pulse");

   // an offer must not move or vanish while the core stalls
   AST_OFFER_HOLDS: assert property (
      fetch_valid_r && !vector_take
      |=> fetch_valid_r && $stable(fetch_addr_r) && $stable(fetch_num_r)
       && $stable(fetch_is_reset_r))
      else $error("offer changed before the core took it");

   // the reset entry has no source, so no acknowledge may follow it
   AST_RESET_NO_ACK: assert property (
      fetch_valid_r && vector_take && fetch_is_reset_r
      |=> irq_ack_r == '0 && !fetch_valid_r)
      else $error("reset entry produced an acknowledge");

   // one-word table at the bottom of memory: slot equals number minus one
   AST_SMALL_BASE: assert property (
      new_irq && !LARGE_VARIANT && !$past(vector_relocate_bit)
      |-> fetch_addr_r == AW'(fetch_num_r - irq_vec_pkg::VEC_RESET))
      else $error("small table slot not one word per vector");

   // two-word relocated table opens two words above the boot start
   AST_LARGE_RELOC: assert property (
      new_irq && LARGE_VARIANT && $past(vector_relocate_bit)
      && fetch_num_r == irq_vec_pkg::VEC_EXT0
      |-> fetch_addr_r == AW'($past(boot_start) + irq_vec_pkg::ADDR_EXT0))
      else $error("relocated table does not start at boot plus two");

   // with requests masked and nothing offered, no interrupt offer appears
   AST_MASKED: assert property (
      !irq_enable && !fetch_valid_r |=> !fetch_valid_r || fetch_is_reset_r)
      else $error("vector offered while requests were masked");

endmodule
`default_nettype wire

// File: vector_fetch_core.sv
// core-side model: accepts each offered vector after a chosen delay.
// assumes the offer holds steady until the edge that takes it.
`timescale 1ns/100ps
`default_nettype none

module vector_fetch_core (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic fetch_valid_r,
   input wire logic [3:0] take_delay,   // cycles to stall before taking
   output logic vector_take
);
   // ==========================================================
   // acceptance timing
   // ==========================================================
   logic [3:0] wait_r;   // cycles the current offer has stood

   // take is raised only while an offer stands and held to its edge,
   // so a stray take with nothing offered never reaches the block
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wait_r <= 4'h0;
         vector_take <= 1'b0;
      end else if (vector_take) begin
         // offer consumed at this edge
         vector_take <= 1'b0;
         wait_r <= 4'h0;
      end else if (fetch_valid_r) begin
         if (wait_r == take_delay) begin
            vector_take <= 1'b1;
         end else begin
            wait_r <= wait_r + 4'h1;   // slow core stalls here
         end
      end else begin
         wait_r <= 4'h0;   // idle, nothing offered
      end
   end
endmodule
`default_nettype wire

// File: interrupt_vector_map_tb.sv
// testbench: two-word and one-word tables side by side on shared inputs.
// assumes both core models use one delay, so both blocks run in step.
`timescale 1ns/100ps
`default_nettype none

module interrupt_vector_map_tb;
   localparam int N = irq_vec_pkg::NUM_SRC;
   localparam int AW = irq_vec_pkg::ADDR_W;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [N-1:0] irq_req = '0;       // source levels
   logic irq_enable = 1'b1;
   logic boot_reset_fuse = 1'b1;     // unprogrammed
   logic vector_relocate_bit = 1'b0;
   logic [AW-1:0] boot_start = 13'h0c00;   // 2K boot section
   logic [3:0] dly = 4'h0;           // core stall before take
   logic lg_take, lg_valid, lg_rst, sm_take, sm_valid, sm_rst;
   logic [AW-1:0] lg_addr, sm_addr;
   logic [4:0] lg_num, sm_num;
   logic [N-1:0] lg_ack, sm_ack;
   int err_total = 0;
   int compares = 0;
   int cycles = 0;

   // ==========================================================
   // clock, blocks and core models
   // ==========================================================
   always #12.5 core_clk = ~core_clk;

   interrupt_vector_map #(.LARGE_VARIANT(1'b1)) u_dut (
      .core_clk(core_clk), .rst_n(rst_n), .irq_req(irq_req),
      .irq_enable(irq_enable), .boot_reset_fuse(boot_reset_fuse),
      .vector_relocate_bit(vector_relocate_bit), .boot_start(boot_start),
      .vector_take(lg_take), .fetch_valid_r(lg_valid),
      .fetch_addr_r(lg_addr), .fetch_num_r(lg_num),
      .fetch_is_reset_r(lg_rst), .irq_ack_r(lg_ack));
   interrupt_vector_map #(.LARGE_VARIANT(1'b0)) u_small (
      .core_clk(core_clk), .rst_n(rst_n), .irq_req(irq_req),
      .irq_enable(irq_enable), .boot_reset_fuse(boot_reset_fuse),
      .vector_relocate_bit(vector_relocate_bit), .boot_start(boot_start),
      .vector_take(sm_take), .fetch_valid_r(sm_valid),
      .fetch_addr_r(sm_addr), .fetch_num_r(sm_num),
      .fetch_is_reset_r(sm_rst), .irq_ack_r(sm_ack));
   vector_fetch_core u_lg_core (.core_clk(core_clk), .rst_n(rst_n),
      .fetch_valid_r(lg_valid), .take_delay(dly), .vector_take(lg_take));
   vector_fetch_core u_sm_core (.core_clk(core_clk), .rst_n(rst_n),
      .fetch_valid_r(sm_valid), .take_delay(dly), .vector_take(sm_take));

   // ==========================================================
   // shared tasks
   // ==========================================================
   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // bounded wait until the two-word block offers a vector
   task automatic wait_offer();
      int i;
      i = 0;
      @(negedge core_clk);
      while (lg_valid !== 1'b1 && i < 40) begin
         @(negedge core_clk);
         i++;
      end
   endtask

   // reset with a fuse setting, then judge the reset entry
   task automatic do_reset(input logic fuse);
      logic [31:0] exp;
      rst_n = 1'b0;
      boot_reset_fuse = fuse;
      repeat (12) @(negedge core_clk);
      rst_n = 1'b1;
      wait_offer();
      exp = fuse ? 32'h0000_0000 : 32'(boot_start);
      check("lg_reset_addr", 32'(lg_addr), exp);
      check("sm_reset_addr", 32'(sm_addr), exp);
      check("lg_reset_num", 32'(lg_num), 32'h0000_0001);
      check("sm_is_reset", 32'(sm_rst), 32'h0000_0001);
      // reset entry is taken without any acknowledge pulse
      repeat (2) @(negedge core_clk);
      check("reset_ack", 32'(lg_ack | sm_ack), 32'h0000_0000);
      check("reset_taken", 32'(lg_valid | sm_valid), 32'h0000_0000);
   endtask

   // raise the sources in mask, expect bit b offered and acknowledged
   task automatic service(input logic [N-1:0] mask, input int b);
      logic [31:0] base, one;
      int i;
      base = vector_relocate_bit ? 32'(boot_start) : 32'h0000_0000;
      one = 32'h0000_0001 << b;
      irq_req = irq_req | mask;
      wait_offer();
      check("lg_addr", 32'(lg_addr), base + 32'((b + 1) * 2));
      check("sm_addr", 32'(sm_addr), base + 32'(b + 1));
      check("lg_num", 32'(lg_num), 32'(b + 2));
      check("sm_num", 32'(sm_num), 32'(b + 2));
      check("lg_is_reset", 32'(lg_rst), 32'h0000_0000);
      i = 0;
      while (lg_ack === '0 && i < 20) begin
         @(negedge core_clk);
         i++;
      end
      check("lg_ack", 32'(lg_ack), one);
      check("sm_ack", 32'(sm_ack), one);
      irq_req[b] = 1'b0;   // source drops once acknowledged
      @(negedge core_clk);
      check("ack_pulse", 32'(lg_ack), 32'h0000_0000);
   endtask

   // ==========================================================
   // scenarios
   // ==========================================================
   // every source alone, prompt core, table at address zero
   task automatic sc_base_table();
      for (int b = 0; b < N; b++) begin
         service(N'(1) << b, b);
      end
   endtask

   // relocated table, first and last interrupt slot of both layouts
   task automatic sc_relocated();
      vector_relocate_bit = 1'b1;
      service(N'(1), 0);
      service(N'(1) << 24, 24);
   endtask

   // two pending at once with a slow core: lowest number first
   task automatic sc_priority();
      dly = 4'h3;
      service((N'(1) << 5) | (N'(1) << 2), 2);
      service('0, 5);
      dly = 4'h0;
   endtask

   // globally masked request is never fetched until enabled
   task automatic sc_masked();
      irq_enable = 1'b0;
      irq_req[10] = 1'b1;
      repeat (6) @(negedge core_clk);
      check("masked_valid", 32'(lg_valid | sm_valid), 32'h0000_0000);
      irq_enable = 1'b1;
      service('0, 10);
   endtask

   // ==========================================================
   // main sequence and hang guard
   // ==========================================================
   // ceiling is some thirty times the under two hundred cycles the run needs
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 5000) begin
         err_total++;
         report_and_stop();
      end
   end

   initial begin
      do_reset(1'b1);
      sc_base_table();
      sc_priority();
      sc_masked();
      sc_relocated();
      do_reset(1'b0);
      service(N'(1) << 1, 1);
      report_and_stop();
   end
endmodule
`default_nettype wire
